// ---- verilog/sofc_pkg.sv ----
`default_nettype none
package sofc_pkg;

	// ==========================================
	// Register indexes (byte address is four times the index).
	localparam logic [7:0] IDX_FRAME_CFG   = 8'h19;
	localparam logic [7:0] IDX_DRIVE       = 8'h1a;
	localparam logic [7:0] IDX_MAPPER      = 8'h1b;
	localparam logic [7:0] IDX_SKEW        = 8'h1e;
	localparam logic [7:0] IDX_PAT_LOW     = 8'h20;
	localparam logic [7:0] IDX_PAT_MID     = 8'h21;
	localparam logic [7:0] IDX_PAT_HIGH    = 8'h22;
	localparam logic [7:0] IDX_MODE        = 8'h30;
	localparam logic [7:0] IDX_STATUS      = 8'h31;

	// ==========================================
	// Writable bit masks; other bits read as zero.
	localparam logic [7:0] MASK_FRAME_CFG  = 8'h91;
	localparam logic [7:0] MASK_DRIVE      = 8'h40;
	localparam logic [7:0] MASK_MAPPER     = 8'hf8;
	localparam logic [7:0] MASK_SKEW       = 8'h0f;
	localparam logic [7:0] MASK_PAT_HIGH   = 8'h0f;
	localparam logic [7:0] MASK_MODE       = 8'h0f;
	localparam logic [7:0] REG_RESET       = 8'h00;

	// ==========================================
	// Field positions.
	localparam int BIT_SRC_SEL     = 7;
	localparam int BIT_DIVIDE      = 4;
	localparam int BIT_STRETCH     = 0;
	localparam int BIT_REDUCED     = 6;
	localparam int BIT_MAPPER_EN   = 7;
	localparam int BIT_WIDE_EN     = 6;
	localparam int POS_REMAP       = 3;
	localparam int POS_DATA_SKEW   = 2;
	localparam int POS_CLK_SKEW    = 0;
	localparam int POS_DECIM       = 0;
	localparam int POS_LANES       = 2;

	// ==========================================
	// Decimation modes and remap codes.
	localparam logic [1:0] DECIM_BYPASS  = 2'h0;
	localparam logic [1:0] DECIM_REAL    = 2'h1;
	localparam logic [1:0] DECIM_COMPLEX = 2'h2;
	localparam logic [2:0] REMAP_18      = 3'h0;
	localparam logic [2:0] REMAP_16      = 3'h1;
	localparam logic [2:0] REMAP_14      = 3'h2;

	// ==========================================
	// Output word widths in bits.
	localparam logic [4:0] WIDTH_NATIVE  = 5'h0e;
	localparam logic [4:0] WIDTH_14      = 5'h0e;
	localparam logic [4:0] WIDTH_16      = 5'h10;
	localparam logic [4:0] WIDTH_18      = 5'h12;
	localparam logic [4:0] WIDTH_WIDE    = 5'h14;
	localparam logic [4:0] PAT_BITS      = 5'h14;

	// Automatic frame pattern: the upper half of the word's bits high.
	function automatic logic [19:0] sofc_auto_pattern(input logic [4:0] width);
		logic [4:0] zeros;
		zeros = PAT_BITS - {1'b0, width[4:1]};
		return 20'hf_ffff << zeros;
	endfunction : sofc_auto_pattern

endpackage : sofc_pkg
`default_nettype wire

// ---- verilog/sofc_frame_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module sofc_frame_gen
	import sofc_pkg::*;
(
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Link bit clock from outside the clock domain.
	input  wire logic        link_bit_clk,
	// Frame settings.
	input  wire logic [19:0] pattern,
	input  wire logic [4:0]  width,
	input  wire logic        divide,
	input  wire logic        stretch,
	// Frame outputs.
	output logic             frame_clock_q,
	output logic             word_start_q
);

	logic       sync1_q;
	logic       sync2_q;
	logic       sync3_q;
	logic       edge_w;
	logic [4:0] idx_q;
	logic       half_q;
	logic [4:0] step_w;
	logic [4:0] next_w;

	// Two flip-flops bring the link clock in; the third finds its rising edges.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= link_bit_clk;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign edge_w = sync2_q & ~sync3_q;
	assign step_w = divide ? 5'h02 : 5'h01;
	assign next_w = idx_q + step_w;

	// Walks the pattern MSB first; stretch holds each bit for two edges.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			idx_q         <= 5'h00;
			half_q        <= 1'b0;
			frame_clock_q <= 1'b0;
			word_start_q  <= 1'b0;
		end else begin
			word_start_q <= 1'b0;
			if (edge_w) begin
				frame_clock_q <= pattern[5'h13 - idx_q];
				half_q        <= stretch & ~half_q;
				if (!stretch || half_q) begin
					word_start_q <= (idx_q == 5'h00);
					idx_q        <= (next_w >= width) ? 5'h00 : next_w;
				end
			end
		end
	end

endmodule : sofc_frame_gen
`default_nettype wire

// ---- verilog/sofc_regs.sv ----
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module sofc_regs
	import sofc_pkg::*;
(
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Link bit clock in.
	input  wire logic        link_bit_clk,
	// Controls to the output formatter.
	output logic             frame_clock,
	output logic             word_start,
	output logic             frame_clock_source_sel,
	output logic             reduced_drive_enable,
	output logic [1:0]       data_skew_select,
	output logic [1:0]       bit_clock_skew_select,
	output logic [4:0]       output_width
);

	logic [7:0]  frame_cfg_q;
	logic [7:0]  drive_q;
	logic [7:0]  mapper_q;
	logic [7:0]  skew_q;
	logic [7:0]  pat_low_q;
	logic [7:0]  pat_mid_q;
	logic [7:0]  pat_high_q;
	logic [7:0]  mode_q;
	logic [4:0]  width_q;
	logic [19:0] pattern_q;
	logic        pready_q;
	logic        wr_en;
	logic [7:0]  idx_w;
	logic [7:0]  rd_w;
	logic        hit_w;
	logic [1:0]  decim_w;
	logic [2:0]  remap_w;
	logic [19:0] soft_pat_w;

	// ==========================================
	// APB decode.
	assign idx_w      = paddr[9:2];
	assign wr_en      = psel & penable & pready_q & pwrite & hit_w;
	assign decim_w    = mode_q[POS_DECIM +: 2];
	assign remap_w    = mapper_q[POS_REMAP +: 3];
	assign soft_pat_w = {pat_high_q[3:0], pat_mid_q, pat_low_q};

	// Read mux; unmapped addresses answer with an error and zero data.
	always_comb begin
		hit_w = 1'b1;
		case (idx_w)
			IDX_FRAME_CFG: rd_w = frame_cfg_q;
			IDX_DRIVE:     rd_w = drive_q;
			IDX_MAPPER:    rd_w = mapper_q;
			IDX_SKEW:      rd_w = skew_q;
			IDX_PAT_LOW:   rd_w = pat_low_q;
			IDX_PAT_MID:   rd_w = pat_mid_q;
			IDX_PAT_HIGH:  rd_w = pat_high_q;
			IDX_MODE:      rd_w = mode_q;
			IDX_STATUS:    rd_w = {3'h0, width_q};
			default: begin
				rd_w  = 8'h00;
				hit_w = 1'b0;
			end
		endcase
	end

	// Every access phase waits one cycle, then completes with registered data.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			prdata   <= 32'h0000_0000;
			pslverr  <= 1'b0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			pslverr  <= psel & penable & ~pready_q & ~hit_w;
			if (psel && penable && !pready_q) begin
				prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_w};
			end
		end
	end
	assign pready = pready_q;

	// Register writes keep only the defined bits.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			frame_cfg_q <= REG_RESET;
			drive_q     <= REG_RESET;
			mapper_q    <= REG_RESET;
			skew_q      <= REG_RESET;
			pat_low_q   <= REG_RESET;
			pat_mid_q   <= REG_RESET;
			pat_high_q  <= REG_RESET;
			mode_q      <= REG_RESET;
		end else if (wr_en) begin
			case (idx_w)
				IDX_FRAME_CFG: frame_cfg_q <= pwdata[7:0] & MASK_FRAME_CFG;
				IDX_DRIVE:     drive_q     <= pwdata[7:0] & MASK_DRIVE;
				IDX_MAPPER:    mapper_q    <= pwdata[7:0] & MASK_MAPPER;
				IDX_SKEW:      skew_q      <= pwdata[7:0] & MASK_SKEW;
				IDX_PAT_LOW:   pat_low_q   <= pwdata[7:0];
				IDX_PAT_MID:   pat_mid_q   <= pwdata[7:0];
				IDX_PAT_HIGH:  pat_high_q  <= pwdata[7:0] & MASK_PAT_HIGH;
				IDX_MODE:      mode_q      <= pwdata[7:0] & MASK_MODE;
				default:       mode_q      <= mode_q;
			endcase
		end
	end

	// ==========================================
	// Output word width from mode, mapper and wide enable.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			width_q <= WIDTH_NATIVE;
		end else if (mapper_q[BIT_WIDE_EN]) begin
			width_q <= WIDTH_WIDE;
		end else if (decim_w == DECIM_BYPASS && !mapper_q[BIT_MAPPER_EN]) begin
			width_q <= WIDTH_NATIVE;
		end else begin
			case (remap_w)
				REMAP_18: width_q <= WIDTH_18;
				REMAP_16: width_q <= WIDTH_16;
				REMAP_14: width_q <= WIDTH_14;
				default:  width_q <= (decim_w == DECIM_COMPLEX) ? WIDTH_16 : WIDTH_18;
			endcase
		end
	end

	// Frame pattern: automatic in bypass, software word otherwise.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pattern_q <= 20'h0_0000;
		end else if (decim_w == DECIM_BYPASS) begin
			pattern_q <= sofc_auto_pattern(width_q);
		end else begin
			pattern_q <= soft_pat_w;
		end
	end

	// Registered copies of the settings for the analog output stage.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			frame_clock_source_sel <= 1'b0;
			reduced_drive_enable   <= 1'b0;
			data_skew_select       <= 2'h0;
			bit_clock_skew_select  <= 2'h0;
			output_width           <= WIDTH_NATIVE;
		end else begin
			frame_clock_source_sel <= frame_cfg_q[BIT_SRC_SEL];
			reduced_drive_enable   <= drive_q[BIT_REDUCED];
			data_skew_select       <= skew_q[POS_DATA_SKEW +: 2];
			bit_clock_skew_select  <= skew_q[POS_CLK_SKEW +: 2];
			output_width           <= width_q;
		end
	end

	// Frame clock generator driven by the link bit clock.
	sofc_frame_gen u_frame_gen (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.link_bit_clk  (link_bit_clk),
		.pattern       (pattern_q),
		.width         (width_q),
		.divide        (frame_cfg_q[BIT_DIVIDE]),
		.stretch       (frame_cfg_q[BIT_STRETCH]),
		.frame_clock_q (frame_clock),
		.word_start_q  (word_start)
	);

	// ==========================================
	// Checks.
	sequence s_quiet3;
		!wr_en [*3];
	endsequence

	property p_wide_width;
		@(posedge ref_clk) disable iff (!rst_n)
		(mapper_q[BIT_WIDE_EN] && !wr_en) ##1 mapper_q[BIT_WIDE_EN] |-> width_q == WIDTH_WIDE;
	endproperty
	a_wide_width: assert property (p_wide_width) else $error("wide width wrong");

	property p_bypass_native;
		@(posedge ref_clk) disable iff (!rst_n)
		(decim_w == DECIM_BYPASS && mapper_q[7:6] == 2'h0 && !wr_en) ##1 s_quiet3
		|-> width_q == WIDTH_NATIVE;
	endproperty
	a_bypass_native: assert property (p_bypass_native) else $error("bypass width wrong");

	property p_remap_16;
		@(posedge ref_clk) disable iff (!rst_n)
		(decim_w == DECIM_REAL && !mapper_q[BIT_WIDE_EN] && remap_w == REMAP_16 && !wr_en)
		##1 s_quiet3
		|-> width_q == WIDTH_16;
	endproperty
	a_remap_16: assert property (p_remap_16) else $error("remap 16 wrong");

	property p_data_skew;
		@(posedge ref_clk) disable iff (!rst_n)
		(wr_en && idx_w == IDX_SKEW) |=> ##1 data_skew_select == $past(pwdata[3:2], 2);
	endproperty
	a_data_skew: assert property (p_data_skew) else $error("data skew wrong");

	property p_clk_skew;
		@(posedge ref_clk) disable iff (!rst_n)
		(wr_en && idx_w == IDX_SKEW) |=> ##1 bit_clock_skew_select == $past(pwdata[1:0], 2);
	endproperty
	a_clk_skew: assert property (p_clk_skew) else $error("clock skew wrong");

	property p_pat_high_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		(psel && penable && !pwrite && !pready && idx_w == IDX_PAT_HIGH)
		|=> pready && prdata[31:4] == 28'h000_0000;
	endproperty
	a_pat_high_zero: assert property (p_pat_high_zero) else $error("pattern high bits");

	property p_soft_pattern;
		@(posedge ref_clk) disable iff (!rst_n)
		(decim_w != DECIM_BYPASS && !wr_en) ##1 s_quiet3 |-> pattern_q == $past(soft_pat_w);
	endproperty
	a_soft_pattern: assert property (p_soft_pattern) else $error("soft pattern wrong");

	property p_auto_pattern;
		@(posedge ref_clk) disable iff (!rst_n)
		(decim_w == DECIM_BYPASS && mapper_q[7:6] == 2'h0 && !wr_en) ##1 s_quiet3
		|-> pattern_q == 20'hf_e000;
	endproperty
	a_auto_pattern: assert property (p_auto_pattern) else $error("auto pattern wrong");

endmodule : sofc_regs
`default_nettype wire

// ---- dv/sofc_link_src.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far-side link clock source.
module sofc_link_src (
	// Frame gate.
	input  wire logic run,
	// Link bit clock.
	output logic      link_bit_clk
);
	// The clock runs only within frames and rests low between them.
	initial begin
		link_bit_clk = 1'b0;
		#37;
		forever begin
			#80;
			link_bit_clk = run ? ~link_bit_clk : 1'b0;
		end
	end
endmodule : sofc_link_src
`default_nettype wire

// ---- dv/serial_output_format_config_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_output_format_config_bench;
	import sofc_pkg::*;
	// ==========================================
	// Signals.
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        link_bit_clk, run, frame_clock, word_start, src_sel, reduced;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  dskew, cskew;
	logic [4:0]  owidth;
	logic [4:0]  ew;
	logic        er;
	logic [31:0] seed, r;
	int          fail_count, n_checks, i, k;
	logic [7:0]  idx_l [8];
	logic [7:0]  msk_l [8];

	// ==========================================
	// Clock and instances.
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	sofc_link_src u_sofc_link_src (.run(run), .link_bit_clk(link_bit_clk));
	sofc_regs u_sofc_regs (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .link_bit_clk(link_bit_clk), .frame_clock(frame_clock),
		.word_start(word_start), .frame_clock_source_sel(src_sel),
		.reduced_drive_enable(reduced), .data_skew_select(dskew),
		.bit_clock_skew_select(cskew), .output_width(owidth));

	// ==========================================
	// Shared tasks.
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// One APB transfer; the request holds until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			fail_count++;
			end_of_test();
		end
	endtask : apb

	// Expected effective output width.
	function automatic logic [4:0] exp_width(input logic [1:0] d, input logic [7:0] m);
		if (m[6]) return WIDTH_WIDE;
		if (d == DECIM_BYPASS && !m[7]) return WIDTH_NATIVE;
		case (m[5:3])
			3'h0: return WIDTH_18;
			3'h1: return WIDTH_16;
			3'h2: return WIDTH_14;
			default: return (d == DECIM_COMPLEX) ? WIDTH_16 : WIDTH_18;
		endcase
	endfunction : exp_width

	// Configures a frame, runs the link and compares the emitted bits.
	task automatic frame_run(input logic [7:0] mode, input logic [7:0] cfg,
		input logic [19:0] pat, input int w, input int step, input int hold);
		int n;
		int j;
		apb(1'b1, IDX_MODE, {24'h0, mode});
		apb(1'b1, IDX_MAPPER, 32'h0000_0000);
		apb(1'b1, IDX_FRAME_CFG, {24'h0, cfg});
		apb(1'b1, IDX_PAT_LOW, {24'h0, pat[7:0]});
		apb(1'b1, IDX_PAT_MID, {24'h0, pat[15:8]});
		apb(1'b1, IDX_PAT_HIGH, {28'h0, pat[19:16]});
		repeat (3) @(posedge ref_clk);
		check("source", {31'h0, src_sel}, {31'h0, cfg[7]});
		run <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (word_start !== 1'b1 && n < 1000);
		if (n >= 1000) begin
			fail_count++;
			end_of_test();
		end
		@(negedge ref_clk);
		for (j = 0; j < w; j += step) begin
			check("frame bit", {31'h0, frame_clock}, {31'h0, pat[19-j]});
			repeat (8 * hold) @(negedge ref_clk);
		end
		// Inputs change only at a rising edge.
		@(posedge ref_clk);
		run <= 1'b0;
		$display("frame test mode %h cfg %h done", mode, cfg);
	endtask : frame_run

	// ==========================================
	// Main sequence.
	initial begin
		seed = 32'h4ab0;
		fail_count = 0;
		n_checks = 0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h000;
		pwdata = 32'h0000_0000;
		run = 1'b0;
		idx_l = '{IDX_DRIVE, IDX_MAPPER, IDX_SKEW, IDX_PAT_LOW, IDX_PAT_MID, IDX_PAT_HIGH,
			IDX_FRAME_CFG, IDX_MODE};
		msk_l = '{MASK_DRIVE, MASK_MAPPER, MASK_SKEW, 8'hff, 8'hff, MASK_PAT_HIGH,
			MASK_FRAME_CFG, MASK_MODE};
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		check("reset width", {27'h0, owidth}, {27'h0, WIDTH_NATIVE});
		for (i = 0; i < 8; i++) begin
			apb(1'b0, idx_l[i], 32'h0000_0000);
			check("reset value", rd, 32'h0000_0000);
			check("mapped err", {31'h0, er}, 32'h0000_0000);
		end
		$display("test reset done");
		// Random writes read back through the writable masks.
		for (k = 0; k < 3; k++) begin
			for (i = 0; i < 8; i++) begin
				r = $random(seed);
				apb(1'b1, idx_l[i], r);
				apb(1'b0, idx_l[i], 32'h0000_0000);
				check("readback", rd, {24'h0, r[7:0] & msk_l[i]});
			end
		end
		apb(1'b0, 8'h55, 32'h0000_0000);
		check("unmapped err", {31'h0, er}, 32'h0000_0001);
		check("unmapped data", rd, 32'h0000_0000);
		$display("test access done");
		// Every skew code and the drive bit reach the outputs.
		for (i = 0; i < 16; i++) begin
			apb(1'b1, IDX_SKEW, i);
			apb(1'b1, IDX_DRIVE, {25'h0, i[0], 6'h00});
			repeat (3) @(posedge ref_clk);
			check("data skew", {30'h0, dskew}, {30'h0, i[3:2]});
			check("clock skew", {30'h0, cskew}, {30'h0, i[1:0]});
			check("drive", {31'h0, reduced}, {31'h0, i[0]});
		end
		$display("test skew done");
		// Width for every remap code under every decimation mode.
		for (k = 0; k < 64; k++) begin
			r = $random(seed);
			apb(1'b1, IDX_MODE, {28'h0, r[3:2], 2'(k % 3)});
			apb(1'b1, IDX_MAPPER, {24'h0, r[7:6], 3'(k / 8), 3'b000});
			repeat (3) @(posedge ref_clk);
			ew = exp_width(2'(k % 3), {r[7:6], 3'(k / 8), 3'b000});
			check("width", {27'h0, owidth}, {27'h0, ew});
			apb(1'b0, IDX_STATUS, 32'h0000_0000);
			check("status", rd, {27'h0, ew});
		end
		$display("test width done");
		// Frame settings per divide, stretch and source option and decimation mode.
		frame_run(8'h00, 8'h00, 20'hf_e000, 14, 1, 1);
		frame_run(8'h00, 8'h10, 20'hf_e000, 14, 2, 1);
		r = $random(seed);
		frame_run(8'h01, 8'h00, r[19:0], 18, 1, 1);
		r = $random(seed);
		frame_run(8'h02, 8'h01, r[19:0], 18, 1, 2);
		frame_run(8'h02, 8'h80, r[19:0], 18, 1, 1);
		// A second reset clears the bank again.
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		check("rereset width", {27'h0, owidth}, {27'h0, WIDTH_NATIVE});
		apb(1'b0, IDX_SKEW, 32'h0000_0000);
		check("rereset value", rd, 32'h0000_0000);
		$display("test second reset done");
		end_of_test();
	end
endmodule : serial_output_format_config_bench
`default_nettype wire
